// file: hw/pms_cfg.svh
// Constants for the power mode sequencer
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_SUP_SYNC_W 2
`define PMS_SEL_24M 1'b1
`define PMS_RST_REQ 1'b0
`endif

// file: hw/pms_pkg.sv
// Types shared by the power mode sequencer
package pms_pkg;
    typedef enum logic [2:0] {
        PMS_NORMAL,
        PMS_IDLE,
        PMS_SUSPEND,
        PMS_SNOOZE,
        PMS_STOP,
        PMS_SHUTDOWN
    } pms_mode_t;

    // Gating controls driven to the clock and analog sections
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic hs_osc_en;
        logic reg_low_bias;
        logic core_reg_en;
        logic analog_en;
        logic pin_hold;
    } pms_gate_t;

    // Software request bits
    typedef struct packed {
        logic idle;
        logic suspend;
        logic snooze;
        logic halt_all;
    } pms_req_t;
endpackage

// file: hw/pms_sync.sv
// Three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/100ps
module pms_sync
(
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic din, // Asynchronous input
    output logic dout // Filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge mclk)
    begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end
    // Change accepted once second and third stages agree
    always_ff @(posedge mclk)
    begin
        if (rst)
            dout <= 1'b0;
        else if (s2_r == s3_r)
            dout <= s3_r;
    end
endmodule

// file: hw/pms_top.sv
// Power mode sequencer: mode state machine, gating and reset hold
// Summary of operation
// - Idle request halts core, peripherals run
// - Interrupt or reset ends Idle
// - Suspend stops core, oscillators; normal bias
// - Snooze stops core, oscillators; low bias
// - Enabled wake or reset ends Suspend/Snooze
// - Halt-all, stop-config clear enters Stop
// - Halt-all, stop-config set enters Shutdown
// - Only pin or power-on reset ends Shutdown
// - Low supply holds device in reset, except in Shutdown
`timescale 1ns/100ps
`include "pms_cfg.svh"
module pms_top
    import pms_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic power_control_reg_idle_set, // Write pulse: idle request
    input wire logic power_control_reg_halt_set, // Write pulse: halt-all request
    input wire logic power_control_reg_two_suspend_set, // Write pulse: suspend request
    input wire logic power_control_reg_two_snooze_set, // Write pulse: snooze request
    input wire logic regulator_off_select, // Stop-config bit of regulator_mode_reg
    input wire logic clock_select_reg_24m, // Clock select shows 24.5 MHz source
    input wire logic irq_pending, // Any enabled interrupt, same clock
    input wire logic wake_pending, // Any enabled wake source, same clock
    input wire logic soft_reset_src, // Internal reset sources, same clock
    input wire logic reset_pin_n, // External reset pin, active low
    input wire logic por_n, // Power-on reset, active low
    input wire logic supply_monitor_ok, // Supply above reset threshold
    output pms_mode_t mode, // Current power mode
    output pms_req_t req_bits, // Request bits as software reads them
    output pms_gate_t gate, // Clock and analog gating
    output logic dev_reset // Device-wide reset
);
    // State, requests and synchronised pin levels
    pms_mode_t mode_r;
    pms_mode_t mode_nxt;
    pms_req_t req_r;
    pms_req_t req_nxt;
    pms_gate_t gate_nxt;
    logic pin_rst_n_s;
    logic por_n_s;
    logic sup_ok_s;
    logic dev_rst_nxt;

    // Synchronised pins read low through rst, so dev_reset holds until they settle
    pms_sync u_pin (.mclk(mclk), .rst(rst), .din(reset_pin_n), .dout(pin_rst_n_s));
    pms_sync u_por (.mclk(mclk), .rst(rst), .din(por_n), .dout(por_n_s));
    pms_sync u_sup (.mclk(mclk), .rst(rst), .din(supply_monitor_ok), .dout(sup_ok_s));

    // Wake and reset conditions per low-power mode
    wire hard_rst = !pin_rst_n_s || !por_n_s;
    wire sup_low = !sup_ok_s;
    wire any_rst = hard_rst || sup_low || soft_reset_src;
    wire clk_ok = (clock_select_reg_24m == `PMS_SEL_24M);
    wire idle_exit = irq_pending || any_rst;
    wire low_exit = wake_pending || any_rst;
    wire stop_exit = any_rst;
    wire shut_exit = hard_rst;

    // Gating for each mode; Normal enables everything
    function automatic pms_gate_t gate_of(input pms_mode_t m);
        pms_gate_t g;
        g.core_clk_en = 1'b1;
        g.periph_clk_en = 1'b1;
        g.hs_osc_en = 1'b1;
        g.reg_low_bias = 1'b0;
        g.core_reg_en = 1'b1;
        g.analog_en = 1'b1;
        g.pin_hold = 1'b0;
        unique case (m)
            PMS_NORMAL: ;
            PMS_IDLE: g.core_clk_en = 1'b0;
            PMS_SUSPEND:
            begin
                g.core_clk_en = 1'b0;
                g.hs_osc_en = 1'b0;
            end
            PMS_SNOOZE:
            begin
                g.core_clk_en = 1'b0;
                g.hs_osc_en = 1'b0;
                g.reg_low_bias = 1'b1;
            end
            PMS_STOP:
            begin
                g.core_clk_en = 1'b0;
                g.periph_clk_en = 1'b0;
                g.hs_osc_en = 1'b0;
                g.pin_hold = 1'b1;
            end
            PMS_SHUTDOWN:
            begin
                g.core_clk_en = 1'b0;
                g.periph_clk_en = 1'b0;
                g.hs_osc_en = 1'b0;
                g.reg_low_bias = 1'b0;
                g.core_reg_en = 1'b0;
                g.analog_en = 1'b0;
                g.pin_hold = 1'b1;
            end
            default: ;
        endcase
        return g;
    endfunction

    // Requests are taken only in Normal; halt outranks the others
    always_comb
    begin
        mode_nxt = mode_r;
        req_nxt = req_r;
        unique case (mode_r)
            PMS_NORMAL:
            begin
                if (power_control_reg_halt_set)
                begin
                    req_nxt.halt_all = 1'b1;
                    mode_nxt = regulator_off_select ? PMS_SHUTDOWN : PMS_STOP;
                end
                // Suspend and snooze are refused unless the 24.5 MHz source is selected
                else if (power_control_reg_two_suspend_set && clk_ok)
                begin
                    req_nxt.suspend = 1'b1;
                    mode_nxt = PMS_SUSPEND;
                end
                else if (power_control_reg_two_snooze_set && clk_ok)
                begin
                    req_nxt.snooze = 1'b1;
                    mode_nxt = PMS_SNOOZE;
                end
                else if (power_control_reg_idle_set)
                begin
                    req_nxt.idle = 1'b1;
                    mode_nxt = PMS_IDLE;
                end
            end
            PMS_IDLE:
                if (idle_exit)
                begin
                    req_nxt.idle = 1'b0;
                    mode_nxt = PMS_NORMAL;
                end
            PMS_SUSPEND, PMS_SNOOZE:
                if (low_exit)
                begin
                    req_nxt.suspend = 1'b0;
                    req_nxt.snooze = 1'b0;
                    mode_nxt = PMS_NORMAL;
                end
            PMS_STOP:
                if (stop_exit)
                begin
                    req_nxt = '0;
                    mode_nxt = PMS_NORMAL;
                end
            PMS_SHUTDOWN:
                if (shut_exit)
                begin
                    req_nxt = '0;
                    mode_nxt = PMS_NORMAL;
                end
            default: mode_nxt = PMS_NORMAL;
        endcase
        gate_nxt = gate_of(mode_nxt);
        // Reset in Shutdown only from pin or power-on; elsewhere any source
        dev_rst_nxt = (mode_r == PMS_SHUTDOWN) ? hard_rst : (any_rst || sup_low);
    end

    // Mode state and request bits
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_r <= PMS_NORMAL;
            req_r <= '0;
        end
        else
        begin
            mode_r <= mode_nxt;
            req_r <= req_nxt;
        end
    end

    // Registered copies seen at the ports
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode <= PMS_NORMAL;
            req_bits <= '0;
        end
        else
        begin
            mode <= mode_nxt;
            req_bits <= req_nxt;
        end
    end

    // Clock and analog gating follows the next mode
    always_ff @(posedge mclk)
    begin
        if (rst)
            gate <= gate_of(PMS_NORMAL);
        else
            gate <= gate_nxt;
    end

    // Device reset is up through rst and until the pins settle
    always_ff @(posedge mclk)
    begin
        if (rst)
            dev_reset <= 1'b1;
        else
            dev_reset <= dev_rst_nxt;
    end
endmodule

// file: test/pms_checker.sv
// Assertion checker for the power mode sequencer
`timescale 1ns/100ps
module pms_checker
    import pms_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic power_control_reg_halt_set, // Halt
    input wire logic regulator_off_select, // Stop-config
    input wire logic irq_pending, // Interrupt
    input wire logic wake_pending, // Wake
    input wire logic soft_reset_src, // Reset source
    input wire logic reset_pin_n, // Pin
    input wire logic por_n, // Power-on
    input wire logic supply_monitor_ok, // Supply
    input wire pms_mode_t mode, // Mode
    input wire pms_req_t req_bits, // Requests
    input wire pms_gate_t gate, // Gating
    input wire logic dev_reset // Reset out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_pins;
        (reset_pin_n && por_n)[*8];
    endsequence
    sequence s_quiet;
        (reset_pin_n && por_n && supply_monitor_ok && !soft_reset_src)[*8];
    endsequence
    a_idle_gate: assert property (mode == PMS_IDLE
        |-> !gate.core_clk_en && gate.periph_clk_en)
        else $error("idle gating wrong");
    a_idle_exit: assert property (mode == PMS_IDLE && irq_pending
        |=> mode == PMS_NORMAL && !req_bits.idle)
        else $error("idle exit wrong");
    a_susp_gate: assert property (mode == PMS_SUSPEND
        |-> !gate.core_clk_en && !gate.hs_osc_en && !gate.reg_low_bias)
        else $error("suspend gating wrong");
    a_snooze_gate: assert property (mode == PMS_SNOOZE
        |-> !gate.core_clk_en && !gate.hs_osc_en && gate.reg_low_bias)
        else $error("snooze gating wrong");
    a_wake_exit: assert property ((mode == PMS_SUSPEND || mode == PMS_SNOOZE)
        && wake_pending |=> mode == PMS_NORMAL && !req_bits.suspend && !req_bits.snooze)
        else $error("wake exit wrong");
    a_halt_entry: assert property (mode == PMS_NORMAL && power_control_reg_halt_set
        && !dev_reset && !soft_reset_src
        |=> mode == ($past(regulator_off_select) ? PMS_SHUTDOWN : PMS_STOP))
        else $error("halt entry wrong");
    a_stop_hold: assert property (s_quiet ##0 mode == PMS_STOP
        |=> mode == PMS_STOP && gate.pin_hold)
        else $error("stop left early");
    a_shut_hold: assert property (s_pins ##0 mode == PMS_SHUTDOWN
        |=> mode == PMS_SHUTDOWN && !gate.core_reg_en)
        else $error("shutdown left early");
    a_supply_hold: assert property ((!supply_monitor_ok && mode != PMS_SHUTDOWN)[*8]
        |-> dev_reset)
        else $error("supply reset missing");
endmodule
bind pms_top pms_checker u_chk (.*);

// file: test/tb.sv
// Directed testbench for the power mode sequencer
`timescale 1ns/100ps
module tb;
    import pms_pkg::*;
    logic mclk = 0, rst = 1, regulator_off_select = 0, clock_select_reg_24m = 0;
    logic irq_pending = 0, wake_pending = 0, soft_reset_src = 0;
    logic reset_pin_n = 1, por_n = 1, supply_monitor_ok = 1, dev_reset;
    logic [3:0] rq = 0;
    pms_mode_t mode;
    pms_req_t req_bits;
    pms_gate_t gate;
    int n_fail = 0, total_checks = 0;
    pms_top dut (.power_control_reg_idle_set(rq[0]), .power_control_reg_halt_set(rq[1]),
        .power_control_reg_two_suspend_set(rq[2]), .power_control_reg_two_snooze_set(rq[3]), .*);
    always #5 mclk = ~mclk;
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic req(input logic [3:0] r);
        rq = r;
        cyc(1);
        rq = 0;
    endtask
    // Waits for the device reset to clear, then expects Normal
    task automatic ready();
        int i;
        for (i = 0; i < 30 && dev_reset !== 1'b0; i++)
            cyc(1);
        if (dev_reset !== 1'b0)
        begin
            chk("ready timeout", dev_reset, 8'h00);
            finish_test();
        end
        chk("mode", mode, PMS_NORMAL);
    endtask
    initial
    begin
        cyc(3);
        rst = 0;
        ready();
        req(4'h1);
        chk("idle", mode, PMS_IDLE);
        chk("idle gate", {gate.core_clk_en, gate.periph_clk_en}, 8'h01);
        chk("idle req", req_bits, 8'h08);
        irq_pending = 1;
        cyc(1);
        irq_pending = 0;
        chk("idle exit", mode, PMS_NORMAL);
        chk("req", req_bits, 8'h00);
        req(4'h4);
        chk("susp refused", mode, PMS_NORMAL);
        clock_select_reg_24m = 1;
        cyc(1);
        req(4'h4);
        chk("susp", mode, PMS_SUSPEND);
        chk("susp gate", {gate.core_clk_en, gate.hs_osc_en, gate.reg_low_bias}, 8'h00);
        wake_pending = 1;
        cyc(1);
        wake_pending = 0;
        chk("susp exit", mode, PMS_NORMAL);
        chk("req", req_bits, 8'h00);
        req(4'h8);
        chk("snooze", mode, PMS_SNOOZE);
        chk("snooze gate", {gate.hs_osc_en, gate.reg_low_bias}, 8'h01);
        soft_reset_src = 1;
        cyc(1);
        soft_reset_src = 0;
        ready();
        req(4'h3);
        chk("stop", mode, PMS_STOP);
        chk("stop gate", {gate.periph_clk_en, gate.core_reg_en, gate.pin_hold}, 8'h03);
        chk("halt req", req_bits, 8'h01);
        wake_pending = 1;
        irq_pending = 1;
        cyc(8);
        chk("stop hold", mode, PMS_STOP);
        wake_pending = 0;
        irq_pending = 0;
        soft_reset_src = 1;
        cyc(1);
        soft_reset_src = 0;
        ready();
        regulator_off_select = 1;
        req(4'h2);
        chk("shutdown", mode, PMS_SHUTDOWN);
        chk("shut gate", {gate.core_reg_en, gate.analog_en, gate.pin_hold}, 8'h01);
        {soft_reset_src, wake_pending, supply_monitor_ok} = 3'b110;
        cyc(8);
        chk("shut hold", mode, PMS_SHUTDOWN);
        {soft_reset_src, wake_pending, supply_monitor_ok} = 3'b001;
        cyc(6);
        reset_pin_n = 0;
        cyc(6);
        chk("pin reset", dev_reset, 8'h01);
        reset_pin_n = 1;
        ready();
        supply_monitor_ok = 0;
        cyc(8);
        chk("supply reset", dev_reset, 8'h01);
        supply_monitor_ok = 1;
        ready();
        req(4'h1);
        rst = 1;
        cyc(2);
        chk("rst hold", dev_reset, 8'h01);
        chk("rst mode", mode, PMS_NORMAL);
        rst = 0;
        ready();
        finish_test();
    end
endmodule
